// ### common/data_move_cfg.svh
// Encodings, field positions and widths for the data-move executor
`ifndef DATA_MOVE_CFG_SVH
`define DATA_MOVE_CFG_SVH

`define DM_INSN_W 14
`define DM_DATA_W 8
`define DM_ADDR_W 7
`define DM_ADDR_MAX 7'h7f
`define DM_DEST_BIT 7
`define DM_W_RESET 8'h00
`define DM_Z_RESET 1'b0
// Opcode match: (insn & mask) == pattern
`define DM_COPY_MASK 14'h3f00
`define DM_COPY_PAT 14'h0800
`define DM_STORE_MASK 14'h3f80
`define DM_STORE_PAT 14'h0080
`define DM_LIT_MASK 14'h3c00
`define DM_LIT_PAT 14'h3000
`define DM_NOP_MASK 14'h3f9f
`define DM_NOP_PAT 14'h0000

`endif

// ### common/data_move_pkg.sv
// Types shared by the data-move executor and its bench
package data_move_pkg;
  `include "data_move_cfg.svh"

  typedef enum logic [2:0] {
    op_none,
    op_copy_file_reg,
    op_store_working_reg,
    op_load_literal_working,
    op_no_operation
  } op_kind_t;

  // Write-back request toward the file register array
  typedef struct packed {
    logic en;
    logic [`DM_ADDR_W-1:0] addr;
    logic [`DM_DATA_W-1:0] data;
  } file_wr_t;

  // Instruction word with its valid strobe
  typedef struct packed {
    logic valid;
    logic [`DM_INSN_W-1:0] word;
  } insn_t;

  typedef struct packed {
    logic [`DM_DATA_W-1:0] working;
    logic zero;
    logic zero_we;
    file_wr_t wr;
    logic done;
    op_kind_t op;
  } exec_state_t;
endpackage

// ### src/data_move_instruction_exec.sv
// Executes copy, store, load-literal and no-operation instructions
`timescale 1ns/1ps
`include "data_move_cfg.svh"

// Overview of operation
// RQ1: Copy reads file reg, writes chosen destination
// RQ2: Select set writes back; clear writes working
// RQ3: Copy sets zero flag from moved value
// RQ4: Store writes working into file register
// RQ5: Load literal places immediate into working
// RQ6: No-operation changes no state
module data_move_instruction_exec #(
  parameter int DATA_W = `DM_DATA_W,
  parameter int ADDR_W = `DM_ADDR_W
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire data_move_pkg::insn_t i_insn,
  input wire logic [DATA_W-1:0] i_file_rd_data,
  output logic [ADDR_W-1:0] o_file_rd_addr,
  output data_move_pkg::file_wr_t o_file_wr,
  output logic [DATA_W-1:0] o_working,
  output logic o_zero,
  output logic o_zero_we,
  output logic o_done,
  output data_move_pkg::op_kind_t o_op
);
  import data_move_pkg::*;

  if (DATA_W != `DM_DATA_W || ADDR_W != `DM_ADDR_W)
  begin : g_bad_width
    $error("Widths must match the instruction encoding");
  end

  function automatic op_kind_t decode(input logic [`DM_INSN_W-1:0] w);
    op_kind_t k;
    k = op_none;
    if ((w & `DM_COPY_MASK) == `DM_COPY_PAT)
      k = op_copy_file_reg;
    else if ((w & `DM_STORE_MASK) == `DM_STORE_PAT)
      k = op_store_working_reg;
    else if ((w & `DM_LIT_MASK) == `DM_LIT_PAT)
      k = op_load_literal_working;
    else if ((w & `DM_NOP_MASK) == `DM_NOP_PAT)
      k = op_no_operation;
    return k;
  endfunction

  exec_state_t state;
  exec_state_t next_state;
  op_kind_t cur_op;
  logic [ADDR_W-1:0] f_addr;
  logic dest_file;
  logic fwd_hit;
  logic [DATA_W-1:0] rd_val;

  // File read is combinational in the same cycle
  assign f_addr = i_insn.word[ADDR_W-1:0];
  assign dest_file = i_insn.word[`DM_DEST_BIT];
  assign cur_op = i_insn.valid ? decode(i_insn.word) : op_none;
  assign o_file_rd_addr = f_addr;
  // Bypass a write-back still in flight to the array
  assign fwd_hit = state.wr.en && state.wr.addr == f_addr;
  assign rd_val = fwd_hit ? state.wr.data : i_file_rd_data;

  always_comb
  begin
    next_state = state;
    next_state.wr.en = 1'b0;
    next_state.zero_we = 1'b0;
    next_state.done = i_insn.valid;
    next_state.op = cur_op;
    case (cur_op)
      op_copy_file_reg:
      begin
        if (dest_file)
        begin
          next_state.wr.en = 1'b1; // [RQ1] [RQ2]
          next_state.wr.addr = f_addr;
          next_state.wr.data = rd_val;
        end
        else
        begin
          next_state.working = rd_val; // [RQ2]
        end
        next_state.zero = (rd_val == '0); // [RQ3]
        next_state.zero_we = 1'b1;
      end
      op_store_working_reg:
      begin
        next_state.wr.en = 1'b1; // [RQ4]
        next_state.wr.addr = f_addr;
        next_state.wr.data = state.working;
      end
      op_load_literal_working:
        next_state.working = i_insn.word[DATA_W-1:0]; // [RQ5]
      op_no_operation:
        next_state.working = state.working; // [RQ6]
      default:
        next_state.working = state.working;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      state <= '0;
      state.working <= `DM_W_RESET;
      state.zero <= `DM_Z_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign o_file_wr = state.wr;
  assign o_working = state.working;
  assign o_zero = state.zero;
  assign o_zero_we = state.zero_we;
  assign o_done = state.done;
  assign o_op = state.op;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);

  AST_COPY_TO_W: assert property ( // [RQ1]
    cur_op == op_copy_file_reg && !dest_file
    |=> o_working == $past(rd_val) && !o_file_wr.en)
  else $error("Copy to working lost value");

  AST_COPY_TO_FILE: assert property ( // [RQ2]
    cur_op == op_copy_file_reg && dest_file
    |=> o_file_wr.en && o_file_wr.addr == $past(f_addr)
        && o_file_wr.data == $past(rd_val)
        && $stable(o_working))
  else $error("Copy write-back wrong");

  AST_COPY_ZERO: assert property ( // [RQ3]
    cur_op == op_copy_file_reg
    |=> o_zero_we && o_zero == ($past(rd_val) == 8'h00))
  else $error("Zero flag wrong after copy");

  AST_ZERO_ONLY_COPY: assert property ( // [RQ3]
    cur_op != op_copy_file_reg |=> !o_zero_we && $stable(o_zero))
  else $error("Zero flag touched by other op");

  AST_STORE: assert property ( // [RQ4]
    cur_op == op_store_working_reg
    |=> o_file_wr.en && o_file_wr.data == $past(o_working)
        && o_file_wr.addr == $past(f_addr) && $stable(o_working))
  else $error("Store did not write working");

  AST_LITERAL: assert property ( // [RQ5]
    cur_op == op_load_literal_working
    |=> o_working == $past(i_insn.word[7:0]) && !o_file_wr.en)
  else $error("Literal not loaded");

  AST_NOP: assert property ( // [RQ6]
    cur_op == op_no_operation
    |=> $stable(o_working) && !o_file_wr.en && !o_zero_we)
  else $error("No-operation changed state");

  AST_DONE_ONE_CYCLE: assert property ( // [RQ1]
    i_insn.valid |=> o_done ##0 o_op == $past(cur_op))
  else $error("Instruction not finished in one cycle");

  AST_FWD_AFTER_STORE: assert property ( // [RQ1]
    cur_op == op_store_working_reg
    ##1 cur_op == op_copy_file_reg && !dest_file && f_addr == $past(f_addr)
    |=> o_working == $past(o_file_wr.data))
  else $error("Copy missed the value just stored");

  AST_COPY_BACK_KEEPS: assert property ( // [RQ2]
    cur_op == op_copy_file_reg && dest_file
    ##1 cur_op == op_copy_file_reg && !dest_file && f_addr == $past(f_addr)
    |=> o_working == $past(o_file_wr.data))
  else $error("Copy after write-back read a stale value");

  AST_REFUSED: assert property ( // [RQ6]
    i_insn.valid && cur_op == op_none
    |=> o_done && o_op == op_none && !o_file_wr.en && !o_zero_we
        && $stable(o_working) && $stable(o_zero))
  else $error("Unknown encoding changed state");

  AST_IDLE: assert property ( // [RQ6]
    !i_insn.valid
    |=> !o_done && !o_file_wr.en && !o_zero_we && $stable(o_working))
  else $error("State changed with no instruction");

  AST_OP_IDLE: assert property ( // [RQ6]
    !i_insn.valid |=> o_op == op_none)
  else $error("Op reported with no instruction");

  AST_STORE_FLAGS: assert property ( // [RQ4]
    cur_op == op_store_working_reg |=> !o_zero_we && $stable(o_zero))
  else $error("Store touched the zero flag");

  AST_LITERAL_FLAGS: assert property ( // [RQ5]
    cur_op == op_load_literal_working |=> !o_zero_we && $stable(o_zero))
  else $error("Literal touched the zero flag");

  AST_WR_SOURCE: assert property ( // [RQ6]
    o_file_wr.en
    |-> o_op == op_copy_file_reg || o_op == op_store_working_reg)
  else $error("File write from an op that must not write");

  AST_ZERO_WE_SOURCE: assert property ( // [RQ3]
    o_zero_we |-> o_op == op_copy_file_reg)
  else $error("Zero strobe from an op other than copy");

  AST_WORKING_SOURCE: assert property ( // [RQ6]
    !$stable(o_working)
    |-> o_op == op_copy_file_reg || o_op == op_load_literal_working)
  else $error("Working register changed by wrong op");

  AST_RESET_VALUES: assert property (disable iff (1'b0)
    i_srst |=> o_working == `DM_W_RESET && o_zero == `DM_Z_RESET
        && !o_done && !o_file_wr.en && !o_zero_we && o_op == op_none)
  else $error("Outputs not cleared by reset");

  CV_COPY_FILE: cover property (cur_op == op_copy_file_reg && dest_file);
  CV_COPY_ZERO: cover property (
    cur_op == op_copy_file_reg && rd_val == 8'h00);
  CV_STORE_THEN_COPY: cover property (
    cur_op == op_store_working_reg ##1 cur_op == op_copy_file_reg);
  CV_LITERAL: cover property (cur_op == op_load_literal_working);
  CV_FWD: cover property (
    cur_op == op_store_working_reg ##1 fwd_hit && cur_op == op_copy_file_reg);
endmodule

// ### test/file_reg_model.sv
// File register array on the far side of the executor
`timescale 1ns/1ps
module file_reg_model (
  input wire logic i_ref_clk,
  input wire logic [6:0] i_addr,
  input wire data_move_pkg::file_wr_t i_wr,
  output logic [7:0] o_data
);
  logic [7:0] mem [128] = '{default: 8'h00};
  // Same-cycle read, write at the edge
  assign o_data = mem[i_addr];
  always @(posedge i_ref_clk)
    if (i_wr.en)
      mem[i_wr.addr] <= i_wr.data;
endmodule

// ### test/tb_top.sv
// Random instruction bench checked against a behavioural model
`timescale 1ns/1ps
module tb_top;
  import data_move_pkg::*;
  logic i_ref_clk = 0;
  logic i_srst = 1;
  insn_t i_insn = '0;
  logic [7:0] rd, o_working, w, z, v, ed, en, we;
  logic [7:0] fm [128] = '{default: 8'h00};
  logic [6:0] ra;
  logic [6:0] last_a = '0;
  logic [13:0] wd;
  file_wr_t wr;
  logic o_zero, o_zero_we, o_done;
  op_kind_t o_op, op;
  int n_fail = 0, num_checks = 0, cyc = 0, k;
  data_move_instruction_exec data_move_instruction_exec_i (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_insn(i_insn),
    .i_file_rd_data(rd), .o_file_rd_addr(ra), .o_file_wr(wr),
    .o_working(o_working), .o_zero(o_zero), .o_zero_we(o_zero_we),
    .o_done(o_done), .o_op(o_op));
  file_reg_model file_reg_model_i (
    .i_ref_clk(i_ref_clk), .i_addr(ra), .i_wr(wr), .o_data(rd));
  initial
  begin
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk)
    if (++cyc > 4000)
    begin
      n_fail++;
      report_and_stop();
    end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    w = 8'h00;
    z = 8'h00;
    void'($urandom(97617));
    repeat (4) @(negedge i_ref_clk);
    i_srst = 0;
    @(negedge i_ref_clk);
    chk(o_working, 8'h00);
    repeat (2000)
    begin
      k = $urandom % 6;
      wd = $urandom;
      case (k)
        0: wd = (wd & 14'h00ff) | 14'h0800;
        1: wd = (wd & 14'h007f) | 14'h0080;
        2: wd = (wd & 14'h03ff) | 14'h3000;
        3: wd = wd & 14'h0060;
        default: wd = (wd & 14'h03ff) | 14'h3800;
      endcase
      // Reuse the last address to hit the write-back bypass
      if (k < 2 && $urandom % 4 == 0)
        wd[6:0] = last_a;
      last_a = wd[6:0];
      i_insn = '{valid: k != 5, word: wd};
      v = fm[wd[6:0]];
      {en, we, ed} = '0;
      op = op_none;
      if (k == 0)
      begin
        op = op_copy_file_reg;
        we = 1;
        z = (v == 0);
        en = wd[7];
        ed = v;
        if (!wd[7])
          w = v;
      end
      if (k == 1)
      begin
        op = op_store_working_reg;
        en = 1;
        ed = w;
        fm[wd[6:0]] = w;
      end
      if (k == 2)
      begin
        op = op_load_literal_working;
        w = wd[7:0];
      end
      if (k == 3)
        op = op_no_operation;
      @(negedge i_ref_clk);
      chk(o_done, k != 5);
      if (k != 5)
        chk(o_op, op);
      chk(o_working, w);
      chk(o_zero, z);
      chk(o_zero_we, we);
      chk(wr.en, en);
      if (en)
      begin
        chk(wr.addr, wd[6:0]);
        chk(wr.data, ed);
      end
    end
    report_and_stop();
  end
endmodule
